// *** inc/flash_erase_regs.svh ***
/*
 * Register offsets, reset values and timing counts of the flash erase
 * controller. Assumes a 50 MHz pclk and byte addresses on a 12-bit APB.
 */
`ifndef FLASH_ERASE_REGS_SVH
`define FLASH_ERASE_REGS_SVH

// Register byte offsets
`define OFS_READY 12'h400
`define OFS_CONFIG 12'h504
`define OFS_PAGE_ERASE 12'h508
`define OFS_WHOLE_ERASE 12'h50C
`define OFS_LEGACY_ALIAS 12'h510
`define OFS_UCFG_ERASE 12'h514
`define OFS_PARTIAL_ERASE 12'h518
`define OFS_PARTIAL_CFG 12'h51C
`define OFS_IRQ_STATUS 12'h600
`define OFS_IRQ_MASK 12'h604

// Field positions and reset values
`define MODE_MSB 1
`define TRIG_BIT 0
`define RST_PARTIAL_CFG 32'h0000000A
`define RST_IRQ_MASK 3'h0
`define IRQ_DONE_BIT 0
`define IRQ_CYCLE_BIT 1
`define IRQ_REFUSED_BIT 2

// Timing: clock, time limits, derived cycle counts
`define CLK_PERIOD_NS 20
`define T_WRITE_US 41
`define T_PAGE_ERASE_MS 85
`define T_WHOLE_ERASE_MS 169
`define T_WRITE_CYC ((`T_WRITE_US * 1000) / `CLK_PERIOD_NS)
`define MS_CYC ((1000000) / `CLK_PERIOD_NS)

`endif

// *** inc/flash_erase_pkg.sv ***
/*
 * Types shared by the flash erase controller and its flash array model.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package flash_erase_pkg;

    typedef enum logic [1:0] {
        AM_READ = 2'h0,
        AM_WRITE = 2'h1,
        AM_ERASE = 2'h2
    } access_mode_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_WRITE = 3'h1,
        OP_PAGE = 3'h2,
        OP_PARTIAL = 3'h3,
        OP_UCFG = 3'h4,
        OP_WHOLE = 3'h5
    } op_kind_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } op_state_t;

endpackage

// *** rtl/op_timer.sv ***
/*
 * Interval timer for flash operations: counts either pclk cycles or
 * millisecond ticks from its own divider, then pulses done.
 * Assumes load is a one-cycle pulse on pclk and is not given while running
 * unless a restart is intended.
 */
`timescale 1ns/1ps
module op_timer #(
    parameter int MS_CYCLES = 50000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic load,
    input wire logic unit_ms,
    input wire logic [31:0] count,
    // Result
    output logic done_r
);

    logic [31:0] left_r;
    logic [31:0] div_r;
    logic run_r;
    logic unit_r;
    wire div_end = (div_r == 32'(MS_CYCLES - 1));
    // Divider restarts on load, so a millisecond step is never short
    wire tick = run_r & (~unit_r | div_end);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_r <= 32'h00000000;
            div_r <= 32'h00000000;
            run_r <= 1'b0;
            unit_r <= 1'b0;
            done_r <= 1'b0;
        end else if (load) begin
            left_r <= count;
            div_r <= 32'h00000000;
            run_r <= 1'b1;
            unit_r <= unit_ms;
            done_r <= 1'b0;
        end else begin
            done_r <= tick & (left_r <= 32'h00000001);
            if (run_r) begin
                div_r <= (div_end | ~unit_r) ? 32'h00000000 : div_r + 32'h1;
            end
            if (tick) begin
                left_r <= left_r - 32'h1;
                if (left_r <= 32'h00000001) begin
                    run_r <= 1'b0;
                end
            end
        end
    end

endmodule

// *** rtl/flash_erase_control.sv ***
/*
 * Erase and program sequencer of the non-volatile memory controller, with
 * its APB register file, interval timer and interrupt status.
 * Assumes a single 50 MHz pclk, an APB master on the same clock, and a
 * flash array that carries out each started operation for as long as
 * the ready flag stays low.
 */
`timescale 1ns/1ps
`include "flash_erase_regs.svh"
module flash_erase_control
    import flash_erase_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Word program request from the bus fabric
    input wire logic prog_req,
    input wire logic [31:0] prog_addr,
    input wire logic [31:0] prog_data,
    // Flash array control
    output logic fl_start,
    output op_kind_t fl_kind,
    output logic [31:0] fl_addr,
    output logic [31:0] fl_data,
    output logic page_cycle,
    // Status
    output logic ready,
    output logic irq
);

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    logic pready_r, pslverr_r, fl_start_r, page_cycle_r, ready_r, irq_r;
    logic [31:0] prdata_r, prdata_nxt, fl_addr_r, fl_data_r, dur_r;
    logic [31:0] acc_page_r, acc_ms_r, acc_sum, tmr_count;
    logic [2:0] sts_r, sts_nxt, mask_r, ev;
    access_mode_t mode_r;
    op_kind_t fl_kind_r, new_kind;
    op_state_t st_r, st_nxt;
    logic tmr_done;

    // Bus decode
    wire acc = psel & penable & pready_r;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire sel_ready = hit(paddr, `OFS_READY);
    wire sel_cfg = hit(paddr, `OFS_CONFIG);
    wire sel_page = hit(paddr, `OFS_PAGE_ERASE);
    wire sel_whole = hit(paddr, `OFS_WHOLE_ERASE);
    wire sel_alias = hit(paddr, `OFS_LEGACY_ALIAS);
    wire sel_ucfg = hit(paddr, `OFS_UCFG_ERASE);
    wire sel_part = hit(paddr, `OFS_PARTIAL_ERASE);
    wire sel_dur = hit(paddr, `OFS_PARTIAL_CFG);
    wire sel_sts = hit(paddr, `OFS_IRQ_STATUS);
    wire sel_mask = hit(paddr, `OFS_IRQ_MASK);
    wire mapped = sel_ready | sel_cfg | sel_page | sel_whole | sel_alias |
        sel_ucfg | sel_part | sel_dur | sel_sts | sel_mask;

    wire t_whole = wr & sel_whole & pwdata[`TRIG_BIT];
    wire t_ucfg = wr & sel_ucfg & pwdata[`TRIG_BIT];
    wire t_page = wr & (sel_page | sel_alias);
    wire t_part = wr & sel_part;
    wire trig_any = t_whole | t_ucfg | t_page | t_part;
    wire idle = (st_r == ST_IDLE);
    wire erase_ok = (mode_r == AM_ERASE) & idle;
    wire go_erase = trig_any & erase_ok;
    wire go_prog = prog_req & (mode_r == AM_WRITE) & idle & ~go_erase;
    wire go = go_erase | go_prog;
    // A refused request still leaves a trace in status bit 2
    wire refused = (trig_any & ~erase_ok) | (prog_req & ~go_prog);
    // code 3 is not a mode and is ignored
    wire mode_ok = (pwdata[`MODE_MSB:0] != 2'h3);

    assign new_kind = go_prog ? OP_WRITE :
        t_whole ? OP_WHOLE :
        t_ucfg ? OP_UCFG :
        t_part ? OP_PARTIAL : OP_PAGE;

    assign tmr_count = (new_kind == OP_WRITE) ? 32'(`T_WRITE_CYC) :
        (new_kind == OP_WHOLE) ? 32'(`T_WHOLE_ERASE_MS) :
        (new_kind == OP_PARTIAL) ? dur_r : 32'(`T_PAGE_ERASE_MS);

    // cumulative time of the page last partially erased
    assign acc_sum = ((fl_addr_r == acc_page_r) ? acc_ms_r : 32'h0) + dur_r;
    wire part_done = tmr_done & (fl_kind_r == OP_PARTIAL);
    wire cycle_hit = part_done & (acc_sum >= 32'(`T_PAGE_ERASE_MS));

    op_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) i_op_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(go),
        .unit_ms(~go_prog),
        .count(tmr_count),
        .done_r(tmr_done)
    );

    // busy from accept to elapsed time
    assign st_nxt = go ? ST_BUSY : (tmr_done ? ST_IDLE : st_r);

    // Events: done, endurance cycle, refused request
    assign ev = {refused, cycle_hit, tmr_done};
    // Hardware set wins over the read clear in the same cycle
    assign sts_nxt = (rd & sel_sts ? 3'h0 : sts_r) | ev;

    assign prdata_nxt = sel_ready ? {31'h0, ready_r} :
        sel_cfg ? {30'h0, mode_r} :
        sel_dur ? dur_r :
        sel_sts ? {29'h0, sts_r} :
        sel_mask ? {29'h0, mask_r} : 32'h00000000;

    // Zero-wait slave: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= psel & ~penable & ~pready_r;
            pslverr_r <= psel & ~penable & ~mapped;
            prdata_r <= (psel & ~penable & ~pwrite) ? prdata_nxt : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= AM_READ;
            dur_r <= `RST_PARTIAL_CFG;
            mask_r <= `RST_IRQ_MASK;
        end else if (wr) begin
            if (sel_cfg && mode_ok) begin
                mode_r <= access_mode_t'(pwdata[`MODE_MSB:0]);
            end
            if (sel_dur) begin
                dur_r <= pwdata;
            end
            if (sel_mask) begin
                mask_r <= pwdata[2:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_IDLE;
            ready_r <= 1'b1;
            fl_start_r <= 1'b0;
            fl_kind_r <= OP_NONE;
            fl_addr_r <= 32'h00000000;
            fl_data_r <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
            ready_r <= (st_nxt == ST_IDLE);
            fl_start_r <= go;
            if (go) begin
                fl_kind_r <= new_kind;
                fl_addr_r <= go_prog ? prog_addr : pwdata;
                fl_data_r <= go_prog ? prog_data : 32'hFFFFFFFF;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_page_r <= 32'h00000000;
            acc_ms_r <= 32'h00000000;
            page_cycle_r <= 1'b0;
            sts_r <= 3'h0;
            irq_r <= 1'b0;
        end else begin
            page_cycle_r <= cycle_hit;
            sts_r <= sts_nxt;
            irq_r <= |(sts_nxt & mask_r);
            // accumulate, count a cycle on reaching page time
            if (part_done) begin
                acc_page_r <= fl_addr_r;
                acc_ms_r <= cycle_hit ? 32'h0 : acc_sum;
            end else if (tmr_done && fl_kind_r != OP_WRITE) begin
                // A full erase leaves no partial time behind
                acc_ms_r <= 32'h0;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign fl_start = fl_start_r;
    assign fl_kind = fl_kind_r;
    assign fl_addr = fl_addr_r;
    assign fl_data = fl_data_r;
    assign page_cycle = page_cycle_r;
    assign ready = ready_r;
    assign irq = irq_r;

    // Cycles since the operation was accepted, for timing checks
    logic [31:0] busy_cyc_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cyc_r <= 32'h00000000;
        end else begin
            busy_cyc_r <= go ? 32'h1 : (ready_r ? 32'h0 : busy_cyc_r + 32'h1);
        end
    end

    // Checks follow pclk and rest while reset holds
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_whole_start: assert property (
        t_whole && erase_ok |=> fl_start_r && fl_kind_r == OP_WHOLE)
        else $error("whole erase not started");
    a_whole_zero: assert property (
        wr && sel_whole && !pwdata[0] && !prog_req |=> !fl_start_r)
        else $error("whole erase started by zero");
    a_alias_page: assert property (
        wr && sel_alias && erase_ok |=>
        fl_kind_r == OP_PAGE && fl_addr_r == $past(pwdata))
        else $error("alias did not start page erase");
    a_ucfg_start: assert property (
        t_ucfg && erase_ok |=> fl_start_r && fl_kind_r == OP_UCFG)
        else $error("config area erase not started");
    a_partial_addr: assert property (
        t_part && erase_ok |=>
        fl_kind_r == OP_PARTIAL && fl_addr_r == $past(pwdata))
        else $error("partial erase wrong page");
    a_dur_write: assert property (
        wr && sel_dur |=> dur_r == $past(pwdata))
        else $error("partial duration not stored");
    a_write_time: assert property (
        !ready_r && fl_kind_r == OP_WRITE |->
        busy_cyc_r <= 32'(`T_WRITE_CYC) + 32'h1)
        else $error("word program too long");
    a_page_time: assert property (
        !ready_r && (fl_kind_r == OP_PAGE || fl_kind_r == OP_UCFG) |->
        busy_cyc_r <= 32'(`T_PAGE_ERASE_MS * MS_CYCLES) + 32'h1)
        else $error("page erase too long");
    a_whole_time: assert property (
        !ready_r && fl_kind_r == OP_WHOLE |->
        busy_cyc_r <= 32'(`T_WHOLE_ERASE_MS * MS_CYCLES) + 32'h1)
        else $error("whole erase too long");
    a_partial_time: assert property (
        tmr_done && fl_kind_r == OP_PARTIAL |->
        busy_cyc_r >= dur_r * 32'(MS_CYCLES))
        else $error("partial step ended early");
    a_ready_state: assert property (
        ready_r |-> st_r == ST_IDLE && !tmr_done)
        else $error("ready while busy");
    a_mode_write: assert property (
        wr && sel_cfg && pwdata[1:0] != 2'h3 |=>
        mode_r == $past(pwdata[1:0]))
        else $error("access mode not stored");
    a_cycle_count: assert property (
        part_done && acc_sum >= 32'(`T_PAGE_ERASE_MS) |=>
        page_cycle_r ##1 !page_cycle_r)
        else $error("endurance cycle not counted");
    a_refuse_mode: assert property (
        trig_any && mode_r != AM_ERASE && !prog_req |=> !fl_start_r)
        else $error("trigger accepted outside erase mode");
    a_busy_next: assert property (
        go |=> !ready_r throughout (!tmr_done [*1]))
        else $error("ready not dropped after trigger");

    // Starts only come from the mode that allows them
    a_erase_mode: assert property (
        fl_start_r && fl_kind_r != OP_WRITE |-> $past(mode_r) == AM_ERASE)
        else $error("erase started outside erase mode");
    a_prog_mode: assert property (
        fl_start_r && fl_kind_r == OP_WRITE |-> $past(mode_r) == AM_WRITE)
        else $error("program started outside write mode");
    a_ucfg_zero: assert property (
        wr && sel_ucfg && !pwdata[0] && !prog_req |=> !fl_start_r)
        else $error("config area erase started by zero");
    a_busy_refuse: assert property (
        trig_any && !idle |=> !fl_start_r && sts_r[`IRQ_REFUSED_BIT])
        else $error("trigger accepted while busy");
    a_ready_read: assert property (
        psel && !penable && !pwrite && sel_ready |=>
        prdata_r == {31'h0, $past(ready_r)})
        else $error("ready register read wrong");
    a_ready_drop: assert property (
        fl_start_r |-> !ready_r)
        else $error("ready high at start");
    a_word_addr: assert property (
        fl_start_r && fl_kind_r == OP_WRITE |->
        fl_addr_r == $past(prog_addr) && fl_data_r == $past(prog_data))
        else $error("program word or address wrong");

    // Interrupt level follows status in the same cycle
    a_irq_level: assert property (
        $stable(mask_r) |-> irq_r == |(sts_r & mask_r))
        else $error("interrupt level wrong");

    c_whole_done: cover property (
        fl_kind_r == OP_WHOLE && tmr_done);
    c_ucfg_done: cover property (fl_kind_r == OP_UCFG && tmr_done);
    c_partial_cycle: cover property (cycle_hit);
    c_refused: cover property (trig_any && !erase_ok);
    c_prog_done: cover property (fl_kind_r == OP_WRITE && tmr_done);

endmodule

// *** bench/flash_array_model.sv ***
/*
 * Flash array model: counts started operations and erase cycles and
 * watches how often one word is programmed between erasures.
 * Assumes the controller's flash control outputs change on pclk.
 */
`timescale 1ns/1ps
module flash_array_model
    import flash_erase_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Operation request
    input wire logic fl_start,
    input wire op_kind_t fl_kind,
    input wire logic [31:0] fl_addr,
    input wire logic page_cycle,
    // Observed counts
    output int starts,
    output int cycles,
    output int viol
);
    int wr_cnt [logic [31:0]];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            starts <= 0;
            cycles <= 0;
            viol <= 0;
        end else begin
            if (page_cycle) begin
                cycles <= cycles + 1;
            end
            if (fl_start) begin
                starts <= starts + 1;
                if (fl_kind == OP_WRITE) begin
                    wr_cnt[fl_addr] = wr_cnt[fl_addr] + 1;
                    if (wr_cnt[fl_addr] > 2) begin
                        viol <= viol + 1;
                    end
                end else begin
                    // Coarse: any erase forgets all program counts
                    wr_cnt.delete();
                end
            end
        end
    end
endmodule

// *** bench/flash_erase_control_tb_top.sv ***
/*
 * Self-checking testbench of flash_erase_control with a flash model.
 * Assumes MS_CYCLES shortened to 10 pclk cycles and one 50 MHz clock.
 */
`timescale 1ns/1ps
`include "flash_erase_regs.svh"
module flash_erase_control_tb_top
    import flash_erase_pkg::*;
    ;
    localparam int MS = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic prog_req = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prog_addr = 32'h0;
    logic [31:0] prog_data = 32'h0;
    logic [31:0] prdata, fl_addr, fl_data, rd;
    logic pready, pslverr, fl_start, page_cycle, ready, irq, er;
    op_kind_t fl_kind;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0, starts, cycles, viol;

    always #10 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    flash_erase_control #(.MS_CYCLES(MS)) i_flash_erase_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prog_req(prog_req),
        .prog_addr(prog_addr), .prog_data(prog_data), .fl_start(fl_start),
        .fl_kind(fl_kind), .fl_addr(fl_addr), .fl_data(fl_data),
        .page_cycle(page_cycle), .ready(ready), .irq(irq));
    flash_array_model i_flash_array_model (
        .pclk(pclk), .presetn(presetn), .fl_start(fl_start),
        .fl_kind(fl_kind), .fl_addr(fl_addr), .page_cycle(page_cycle),
        .starts(starts), .cycles(cycles), .viol(viol));

    task automatic chk(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic hang(input string nm);
        error_cnt++;
        $display("timeout in %s", nm);
        print_verdict();
    endtask

    // Request held until pready is sampled, released only after it
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang("apb");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic trig(input logic [11:0] a, input logic [31:0] d,
            input op_kind_t k);
        apb(1'b1, a, d);
        #1;
        t0 = cyc;
        chk("fl_start", 32'(fl_start), 32'h1);
        chk("ready", 32'(ready), 32'h0);
        chk("fl_kind", 32'(fl_kind), 32'(k));
        chk("fl_addr", fl_addr, d);
    endtask

    task automatic wait_ready(input int lo, input int hi);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < hi + 50) begin
            @(posedge pclk);
            n++;
        end
        if (ready !== 1'b1) hang("busy");
        n = cyc - t0;
        chk("busy not short", 32'(n >= lo), 32'h1);
        chk("busy not long", 32'(n <= hi), 32'h1);
    endtask

    task automatic t_reset();
        chk("ready pin", 32'(ready), 32'h1);
        apb(1'b0, `OFS_READY, 32'h0);
        chk("ready reg", rd, 32'h1);
        apb(1'b0, `OFS_PARTIAL_CFG, 32'h0);
        chk("duration reg", rd, `RST_PARTIAL_CFG);
        $display("test reset done");
    endtask

    task automatic t_mode();
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `OFS_CONFIG, 32'(m));
            apb(1'b0, `OFS_CONFIG, 32'h0);
            chk("mode", rd, (m == 3) ? 32'h2 : 32'(m));
        end
        $display("test mode done");
    endtask

    task automatic t_refuse();
        apb(1'b1, `OFS_CONFIG, 32'h1);
        apb(1'b1, `OFS_PAGE_ERASE, 32'h0000_1000);
        #1;
        chk("start wrong mode", 32'(fl_start), 32'h0);
        apb(1'b1, `OFS_CONFIG, 32'h2);
        apb(1'b1, `OFS_WHOLE_ERASE, 32'h0);
        #1;
        chk("start on zero", 32'(fl_start), 32'h0);
        chk("ready on zero", 32'(ready), 32'h1);
        apb(1'b1, `OFS_UCFG_ERASE, 32'h0);
        #1;
        chk("ucfg on zero", 32'(fl_start), 32'h0);
        apb(1'b0, 12'h700, 32'h0);
        chk("unmapped err", 32'(er), 32'h1);
        $display("test refuse done");
    endtask

    task automatic t_erase();
        trig(`OFS_WHOLE_ERASE, 32'h1, OP_WHOLE);
        apb(1'b0, `OFS_READY, 32'h0);
        chk("ready reg busy", rd, 32'h0);
        apb(1'b1, `OFS_PAGE_ERASE, 32'h0000_1000);
        #1;
        chk("start while busy", 32'(fl_start), 32'h0);
        wait_ready(169 * MS, 169 * MS + 6);
        trig(`OFS_UCFG_ERASE, 32'h1, OP_UCFG);
        wait_ready(85 * MS, 85 * MS + 6);
        trig(`OFS_LEGACY_ALIAS, 32'h0000_2000, OP_PAGE);
        wait_ready(85 * MS, 85 * MS + 6);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq masked", 32'(irq), 32'h0);
        $display("test erase done");
    endtask

    task automatic t_partial();
        int c;
        apb(1'b1, `OFS_PARTIAL_CFG, 32'h0000002B);
        apb(1'b0, `OFS_PARTIAL_CFG, 32'h0);
        chk("duration rw", rd, 32'h0000002B);
        c = cycles;
        // Two steps of 43 reach the 85 ms page time
        for (int s = 0; s < 2; s++) begin
            trig(`OFS_PARTIAL_ERASE, 32'h0000_3000, OP_PARTIAL);
            wait_ready(43 * MS, 43 * MS + 43 * MS / 20 + 4);
            // The model counts on the edge that ends the wait
            #1;
            chk("erase cycles", 32'(cycles - c), 32'(s));
            @(posedge pclk);
            #1;
        end
        chk("erase cycles end", 32'(cycles - c), 32'h1);
        $display("test partial done");
    endtask

    task automatic t_prog();
        apb(1'b1, `OFS_CONFIG, 32'h1);
        prog_addr <= 32'h0000_4000;
        prog_data <= 32'hA5A5_0F0F;
        prog_req <= 1'b1;
        @(posedge pclk);
        prog_req <= 1'b0;
        #1;
        t0 = cyc;
        chk("prog start", 32'(fl_start), 32'h1);
        chk("prog kind", 32'(fl_kind), 32'(OP_WRITE));
        chk("prog data", fl_data, 32'hA5A5_0F0F);
        wait_ready(`T_WRITE_CYC, `T_WRITE_CYC + 4);
        $display("test program done");
    endtask

    task automatic t_irq();
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
        apb(1'b1, `OFS_IRQ_MASK, 32'h1);
        apb(1'b1, `OFS_CONFIG, 32'h2);
        trig(`OFS_PAGE_ERASE, 32'h0000_5000, OP_PAGE);
        wait_ready(85 * MS, 85 * MS + 6);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq raised", 32'(irq), 32'h1);
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
        chk("status done", rd, 32'h1);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq cleared", 32'(irq), 32'h0);
        $display("test interrupt done");
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_mode();
        t_refuse();
        t_erase();
        t_partial();
        t_prog();
        t_irq();
        chk("program overuse", 32'(viol), 32'h0);
        chk("starts", 32'(starts), 32'h7);
        print_verdict();
    end

    initial begin
        #400_000;
        hang("run");
    end
endmodule
